// ---- logic/hsb_pkg.sv ----
// Purpose: Shared constants and carriers for the health and raw sensor bank
// Assumes: APB with 32-bit data, offsets are word indexes (byte = 4 * index)
// Notes:   All timing counts derive from the 10 MHz clock
package hsb_pkg;

  // ==========================================================================
  // Register indexes and bus geometry
  // ==========================================================================
  localparam logic [7:0] IDX_HEALTH     = 8'h55;  // Health word
  localparam logic [7:0] IDX_RATE_XY    = 8'h56;  // Rotation raw X/Y
  localparam logic [7:0] IDX_RATE_Z     = 8'h57;  // Rotation raw Z
  localparam logic [7:0] IDX_RATE_TS    = 8'h58;  // Rotation timestamp
  localparam logic [7:0] IDX_LIN_XY     = 8'h59;  // Linear raw X/Y
  localparam logic [7:0] IDX_LIN_Z      = 8'h5a;  // Linear raw Z
  localparam logic [7:0] IDX_LIN_TS     = 8'h5b;  // Linear timestamp
  localparam logic [7:0] IDX_FLD_XY     = 8'h5c;  // Field raw X/Y
  localparam logic [7:0] IDX_FLD_Z      = 8'h5d;  // Field raw Z
  localparam logic [7:0] IDX_FLD_TS     = 8'h5e;  // Field timestamp
  localparam logic [7:0] IDX_TEMP       = 8'h5f;  // Temperature
  localparam logic [7:0] IDX_TEMP_TS    = 8'h60;  // Temperature timestamp
  localparam logic [7:0] IDX_RATE_CAL_X = 8'h61;  // Calibrated rate X
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h62;  // Event status, clear on read
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h63;  // Event mask
  localparam int         ADDR_W         = 10;     // Byte address width
  localparam int         IDX_LSB        = 2;      // Word index starts here

  // ==========================================================================
  // Health word field positions
  // ==========================================================================
  localparam int HW_FIX_LSB  = 26;  // Satellites in fix, 31:26
  localparam int HW_HORIZONTAL_PRECISION_DILUTION_LSB = 16;  // Precision dilution, 25:16
  localparam int HW_VIS_LSB  = 10;  // Visible satellites, 15:10
  localparam int HW_OVF_BIT  = 8;   // Transmit overflow
  localparam int HW_FN_BIT   = 5;   // Field norm warning
  localparam int HW_AN_BIT   = 4;   // Acceleration norm warning
  localparam int HW_LF_BIT   = 3;   // Linear sensor init failure
  localparam int HW_RF_BIT   = 2;   // Rate sensor init failure
  localparam int HW_MF_BIT   = 1;   // Field sensor init failure
  localparam int HW_TO_BIT   = 0;   // Receiver timeout

  // ==========================================================================
  // Event bits of status and mask
  // ==========================================================================
  localparam int EV_TIMEOUT  = 0;   // Receiver timeout rose
  localparam int EV_OVF      = 1;   // Overflow rose
  localparam int EV_NORM     = 2;   // A norm warning rose
  localparam int EV_SAMPLE   = 3;   // New rotation sample captured
  localparam int EV_W        = 4;   // Event count

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam longint CLK_HZ        = 10000000;  // Clock rate
  localparam longint RX_TIMEOUT_MS = 2000;      // Receiver silence limit
  localparam longint RX_TIMEOUT_CYC = CLK_HZ * RX_TIMEOUT_MS / 1000;
  localparam int     TO_CNT_W      = 32;        // Timeout counter width

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;  // Reset / unmapped data

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [15:0] x;  // Signed X sample
    logic [15:0] y;  // Signed Y sample
    logic [15:0] z;  // Signed Z sample
    logic [31:0] ts; // Float timestamp
  } hsb_axes_s;

  typedef struct packed {
    logic [5:0] fix_count;    // Satellites in fix
    logic [9:0] horizontal_precision_dilution;         // Precision times ten
    logic [5:0] vis_count;    // Visible satellites
  } hsb_gnss_s;

endpackage

// ---- logic/hsb_bank.sv ----
// Purpose: Health and raw sensor register bank on APB, read-only except the event mask
// Assumes: Sensor front ends and receiver parser run on the same clock
// Notes:   Asynchronous status levels pass a two-flop synchroniser
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps

// What this block does
// - Satellites in fix in bits 31:26
// - Precision dilution times ten in 25:16
// - Visible satellite count in bits 15:10
// - Overflow flag when traffic exceeds baud
// - Field norm warning bit 5
// - Acceleration norm warning bit 4
// - Linear sensor init failure bit 3
// - Rate sensor init failure bit 2
// - Field sensor init failure bit 1
// - Timeout after two silent seconds, bit 0
// - Any receiver packet clears timeout
// - Bits 9 and 7:6 read zero
// - X upper, Y lower, signed 16-bit
// - Z upper half, lower half zero
// - Per-sensor float timestamp word
// - Float temperature plus float timestamp
// - Calibrated X rotation rate as float
module hsb_bank
  import hsb_pkg::*;
#(
  parameter longint TIMEOUT_CYC = RX_TIMEOUT_CYC  // Receiver silence cycles
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Sensor samples, each with one-cycle valid
  input  wire hsb_axes_s         rate_raw,
  input  wire logic              rate_valid,
  input  wire hsb_axes_s         linear_raw,
  input  wire logic              linear_valid,
  input  wire hsb_axes_s         field_raw,
  input  wire logic              field_valid,
  input  wire logic [31:0]       temperature,
  input  wire logic [31:0]       temperature_ts,
  input  wire logic              temperature_valid,
  input  wire logic [31:0]       rate_cal_x,
  input  wire logic              rate_cal_valid,
  // Receiver fix data and packet strobe
  input  wire hsb_gnss_s         gnss,
  input  wire logic              gnss_packet,
  // Status levels from other domains
  input  wire logic              transmit_overflow_flag,
  input  wire logic              field_norm_warning,
  input  wire logic              acceleration_norm_warning,
  input  wire logic              linear_init_fail,
  input  wire logic              rate_init_fail,
  input  wire logic              field_init_fail,
  // Interrupt
  output logic                   irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  localparam int SY_W = 6;  // Synchronised status levels

  typedef struct packed {
    logic [SY_W-1:0]     sync1;      // First synchroniser stage
    logic [SY_W-1:0]     sync2;      // Second synchroniser stage
    logic [SY_W-1:0]     sync3;      // Delayed copy for edge detection
    hsb_gnss_s           gnss;       // Latched fix data
    logic                timeout;    // Receiver timeout flag
    logic [TO_CNT_W-1:0] silence;    // Cycles since last packet
    hsb_axes_s           rate;       // Rotation sample
    hsb_axes_s           linear;     // Linear sample
    hsb_axes_s           field;      // Field sample
    logic [31:0]         temp;       // Temperature
    logic [31:0]         temp_ts;    // Temperature time
    logic [31:0]         cal_x;      // Calibrated rate X
    logic [EV_W-1:0]     status;     // Sticky events
    logic [EV_W-1:0]     mask;       // Event mask
    logic [31:0]         rdata;      // Read data
    logic                ready;      // Access answered
    logic                err;        // Unmapped access or refused write
    logic                irq;        // Interrupt level
  } hsb_state_s;

  hsb_state_s state;       // Registered state
  hsb_state_s next_state;  // Next state

  localparam logic [TO_CNT_W-1:0] TO_LIMIT = TO_CNT_W'(TIMEOUT_CYC);

  // Health word assembly, reserved bits stay zero
  function automatic logic [31:0] health_word(input hsb_state_s s);
    logic [31:0] w;
    w = ZERO_WORD;
    w[HW_FIX_LSB +: 6]  = s.gnss.fix_count;
    w[HW_HORIZONTAL_PRECISION_DILUTION_LSB +: 10] = s.gnss.horizontal_precision_dilution;
    w[HW_VIS_LSB +: 6]  = s.gnss.vis_count;
    w[HW_OVF_BIT] = s.sync2[0];
    w[HW_FN_BIT]  = s.sync2[1];
    w[HW_AN_BIT]  = s.sync2[2];
    w[HW_LF_BIT]  = s.sync2[3];
    w[HW_RF_BIT]  = s.sync2[4];
    w[HW_MF_BIT]  = s.sync2[5];
    w[HW_TO_BIT]  = s.timeout;
    return w;
  endfunction

  // X/Y pair and Z word formats
  function automatic logic [31:0] xy_word(input hsb_axes_s a);
    return {a.x, a.y};
  endfunction

  function automatic logic [31:0] z_word(input hsb_axes_s a);
    return {a.z, 16'h0000};
  endfunction

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    logic [EV_W-1:0] ev;
    logic [7:0]      idx;
    logic            acc;
    logic            hit;
    logic [31:0]     rd;
    ev  = '0;
    idx = paddr[IDX_LSB +: 8];
    acc = psel && penable && !state.ready;
    hit = 1'b1;
    rd  = ZERO_WORD;
    next_state = state;
    // Synchronise asynchronous levels
    next_state.sync1 = {field_init_fail, rate_init_fail, linear_init_fail,
                        acceleration_norm_warning, field_norm_warning,
                        transmit_overflow_flag};
    next_state.sync2 = state.sync1;
    next_state.sync3 = state.sync2;
    // Receiver timeout tracking
    if (gnss_packet) begin
      next_state.gnss    = gnss;
      next_state.silence = '0;
      next_state.timeout = 1'b0;
    end else if (state.silence >= TO_LIMIT) begin
      next_state.timeout = 1'b1;
    end else begin
      next_state.silence = state.silence + 1'b1;
    end
    // Whole-word sample capture
    if (rate_valid) begin
      next_state.rate = rate_raw;
    end
    if (linear_valid) begin
      next_state.linear = linear_raw;
    end
    if (field_valid) begin
      next_state.field = field_raw;
    end
    if (temperature_valid) begin
      next_state.temp    = temperature;
      next_state.temp_ts = temperature_ts;
    end
    if (rate_cal_valid) begin
      next_state.cal_x = rate_cal_x;
    end
    // Rising-edge events, plus the rotation sample strobe
    ev[EV_TIMEOUT] = next_state.timeout && !state.timeout;
    // Edges taken past the second stage only, never from the first
    ev[EV_OVF]     = state.sync2[0] && !state.sync3[0];
    ev[EV_NORM]    = |(state.sync2[2:1] & ~state.sync3[2:1]);
    ev[EV_SAMPLE]  = rate_valid;
    // Register read decode
    unique case (idx)
      IDX_HEALTH:     rd = health_word(state);
      IDX_RATE_XY:    rd = xy_word(state.rate);
      IDX_RATE_Z:     rd = z_word(state.rate);
      IDX_RATE_TS:    rd = state.rate.ts;
      IDX_LIN_XY:     rd = xy_word(state.linear);
      IDX_LIN_Z:      rd = z_word(state.linear);
      IDX_LIN_TS:     rd = state.linear.ts;
      IDX_FLD_XY:     rd = xy_word(state.field);
      IDX_FLD_Z:      rd = z_word(state.field);
      IDX_FLD_TS:     rd = state.field.ts;
      IDX_TEMP:       rd = state.temp;
      IDX_TEMP_TS:    rd = state.temp_ts;
      IDX_RATE_CAL_X: rd = state.cal_x;
      IDX_IRQ_STATUS: rd = {{(32-EV_W){1'b0}}, state.status};
      IDX_IRQ_MASK:   rd = {{(32-EV_W){1'b0}}, state.mask};
      default:        hit = 1'b0;
    endcase
    // Access phase answered in its second cycle, one wait state
    next_state.ready = acc;
    next_state.err   = 1'b0;
    next_state.rdata = ZERO_WORD;
    next_state.status = state.status;
    if (acc) begin
      // Writes to read-only words are refused
      next_state.err = !hit || (pwrite && idx != IDX_IRQ_MASK);
      if (!pwrite && hit) begin
        next_state.rdata = rd;
        if (idx == IDX_IRQ_STATUS) begin
          next_state.status = '0;                     // Clear on read
        end
      end
      if (pwrite && idx == IDX_IRQ_MASK) begin
        next_state.mask = pwdata[EV_W-1:0];
      end
    end
    // Set wins over clear
    next_state.status = next_state.status | ev;
    next_state.irq    = |(next_state.status & next_state.mask);
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flops
  assign prdata  = state.rdata;
  assign pready  = state.ready;
  assign pslverr = state.err;
  assign irq     = state.irq;

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_timeout_sets: assert property (@(posedge clock) disable iff (rst)
    (!gnss_packet && state.silence >= TO_LIMIT) |=> state.timeout)
    else $error("timeout flag did not set");
  chk_packet_clears: assert property (@(posedge clock) disable iff (rst)
    gnss_packet |=> !state.timeout ##0 state.silence == '0)
    else $error("packet did not clear timeout");
  chk_reserved_zero: assert property (@(posedge clock) disable iff (rst)
    (pready && !pslverr && $past(paddr[IDX_LSB +: 8]) == IDX_HEALTH)
      |-> (prdata[9] == 1'b0 && prdata[7:6] == 2'b00))
    else $error("reserved health bits not zero");
  chk_fix_field: assert property (@(posedge clock) disable iff (rst)
    (pready && $past(paddr[IDX_LSB +: 8]) == IDX_HEALTH && $past(!pwrite))
      |-> prdata[31:26] == $past(state.gnss.fix_count))
    else $error("fix count misplaced");
  chk_horizontal_precision_dilution_field: assert property (@(posedge clock) disable iff (rst)
    (pready && $past(paddr[IDX_LSB +: 8]) == IDX_HEALTH && $past(!pwrite))
      |-> (prdata[25:16] == $past(state.gnss.horizontal_precision_dilution)
           && prdata[15:10] == $past(state.gnss.vis_count)))
    else $error("precision or visible count misplaced");
  chk_ovf_follows: assert property (@(posedge clock) disable iff (rst)
    $rose(transmit_overflow_flag) ##1 transmit_overflow_flag
      |=> state.sync2[0])
    else $error("overflow not reflected");
  chk_init_fail: assert property (@(posedge clock) disable iff (rst)
    (linear_init_fail && rate_init_fail && field_init_fail)[*3]
      |-> state.sync2[5:3] == 3'b111)
    else $error("init failure not reflected");
  chk_norm_flags: assert property (@(posedge clock) disable iff (rst)
    (field_norm_warning && acceleration_norm_warning)[*3]
      |-> state.sync2[2:1] == 2'b11)
    else $error("norm warning not reflected");
  chk_xy_coherent: assert property (@(posedge clock) disable iff (rst)
    rate_valid |=> {state.rate.x, state.rate.y} == $past({rate_raw.x, rate_raw.y}))
    else $error("axis pair not captured together");
  chk_temp_pair: assert property (@(posedge clock) disable iff (rst)
    temperature_valid |=> state.temp == $past(temperature)
      && state.temp_ts == $past(temperature_ts))
    else $error("temperature pair mismatch");
  chk_ready_once: assert property (@(posedge clock) disable iff (rst)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("ready not a single pulse");

  cov_timeout: cover property (@(posedge clock) disable iff (rst) $rose(state.timeout));
  cov_health_read: cover property (@(posedge clock) disable iff (rst)
    pready && !pslverr && $past(paddr[IDX_LSB +: 8]) == IDX_HEALTH);
  cov_irq: cover property (@(posedge clock) disable iff (rst) $rose(irq));
  cov_unmapped: cover property (@(posedge clock) disable iff (rst) pready && pslverr);

endmodule

// ---- test/hsb_host.sv ----
// Purpose: APB host model that reads and writes the sensor bank
// Assumes: One transfer at a time, request held until pready
// Notes:   Released address and data lines show the inverse value
`timescale 1ns/1ps
module hsb_host
  import hsb_pkg::*;
(
  // Clock
  input  wire logic              clock,
  // APB master side
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [ADDR_W-1:0] paddr,
  output logic      [31:0]       pwdata,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  // ==========================================================================
  // Idle bus
  // ==========================================================================
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  // ==========================================================================
  // One transfer: setup, access until pready seen high at an edge
  // ==========================================================================
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 32);
    rd = prdata;
    err = (n < 32) ? pslverr : 1'bx;
    // Release, and leave no stale address or data on the lines
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule

// ---- test/hsb_bank_tb_top.sv ----
// Purpose: Self-checking bench of the health and raw sensor bank
// Assumes: Receiver silence limit shortened to TO_SIM cycles
// Notes:   Random sensor and status values from a fixed seed
`timescale 1ns/1ps
module hsb_bank_tb_top;
  import hsb_pkg::*;
  localparam int TO_SIM = 50;  // Shortened silence limit
  logic              clock, rst, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd, temperature, temperature_ts, rate_cal_x;
  hsb_axes_s         rate_raw, linear_raw, field_raw, a;
  logic              rate_valid, linear_valid, field_valid, temperature_valid;
  logic              rate_cal_valid, gnss_packet;
  hsb_gnss_s         gnss;
  logic [5:0]        lv;  // Overflow, field norm, accel norm, three init fails
  int                errors, total_checks, cycles;

  // ==========================================================================
  // Design, host model, clock
  // ==========================================================================
  hsb_bank #(.TIMEOUT_CYC(TO_SIM)) u_hsb_bank (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rate_raw, .rate_valid, .linear_raw, .linear_valid, .field_raw, .field_valid,
    .temperature, .temperature_ts, .temperature_valid, .rate_cal_x, .rate_cal_valid,
    .gnss, .gnss_packet, .transmit_overflow_flag(lv[5]), .field_norm_warning(lv[4]),
    .acceleration_norm_warning(lv[3]), .linear_init_fail(lv[2]),
    .rate_init_fail(lv[1]), .field_init_fail(lv[0]), .irq
  );
  hsb_host u_hsb_host (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                       .pready, .pslverr);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ==========================================================================
  // Expectations, compares, helpers
  // ==========================================================================
  function automatic logic [31:0] exp_health(hsb_gnss_s g, logic [5:0] l, logic to);
    return {g.fix_count, g.horizontal_precision_dilution, g.vis_count, 1'b0, l[5], 2'b00, l[4:0], to};
  endfunction
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read a register, expect data and an OK response
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    u_hsb_host.xfer(1'b0, idx, 32'h0, rd, err);
    chk_word(rd, exp);
    chk_flag(err, 1'b0);
  endtask
  task automatic pulse_packet();
    @(posedge clock);
    gnss_packet <= 1'b1;
    @(posedge clock);
    gnss_packet <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      end_sim();
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst = 1'b1;
    {rate_valid, linear_valid, field_valid, temperature_valid} = '0;
    {rate_cal_valid, gnss_packet, lv, gnss} = '0;
    {rate_raw, linear_raw, field_raw} = '0;
    {temperature, temperature_ts, rate_cal_x} = '0;
    {errors, total_checks, cycles} = '0;
    void'($urandom(32'h075c));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    // Reset contents
    rd_chk(IDX_HEALTH, 32'h0);
    rd_chk(IDX_RATE_XY, 32'h0);
    rd_chk(IDX_IRQ_MASK, 32'h0);
    $display("test reset done");
    // Sensor words, first pass with signed extremes on the field sensor
    for (int p = 0; p < 3; p++) begin
      @(posedge clock);
      rate_raw <= {$urandom(), $urandom(), 16'($urandom())};
      linear_raw <= {$urandom(), $urandom(), 16'($urandom())};
      field_raw <= (p == 0) ? {16'h8000, 16'h7fff, 16'hffff, 32'h0} :
                   {$urandom(), $urandom(), 16'($urandom())};
      {temperature, temperature_ts, rate_cal_x} <= {$urandom(), $urandom(), $urandom()};
      {rate_valid, linear_valid, field_valid, temperature_valid, rate_cal_valid} <= '1;
      @(posedge clock);
      {rate_valid, linear_valid, field_valid, temperature_valid, rate_cal_valid} <= '0;
      for (int s = 0; s < 3; s++) begin
        a = (s == 0) ? rate_raw : (s == 1) ? linear_raw : field_raw;
        rd_chk(8'(IDX_RATE_XY + 3 * s), {a.x, a.y});
        rd_chk(8'(IDX_RATE_XY + 3 * s + 1), {a.z, 16'h0000});
        rd_chk(8'(IDX_RATE_XY + 3 * s + 2), a.ts);
      end
      rd_chk(IDX_TEMP, temperature);
      rd_chk(IDX_TEMP_TS, temperature_ts);
      rd_chk(IDX_RATE_CAL_X, rate_cal_x);
    end
    $display("test sensors done");
    // Health word packing, first pass all ones
    for (int p = 0; p < 4; p++) begin
      @(posedge clock);
      gnss <= (p == 0) ? '1 : hsb_gnss_s'($urandom());
      lv <= (p == 0) ? '1 : 6'($urandom());
      pulse_packet();
      repeat (3) @(posedge clock);
      rd_chk(IDX_HEALTH, exp_health(gnss, lv, 1'b0));
      chk_word(rd, exp_health(gnss, lv, 1'b0));
      chk_flag(irq, 1'b0);
    end
    // Host lowers its rates, overflow clears
    lv <= '0;
    $display("test health done");
    // Refused accesses and the mask
    u_hsb_host.xfer(1'b1, IDX_HEALTH, 32'hffff_ffff, rd, err);
    chk_flag(err, 1'b1);
    u_hsb_host.xfer(1'b0, 8'h70, 32'h0, rd, err);
    chk_flag(err, 1'b1);
    u_hsb_host.xfer(1'b1, IDX_IRQ_MASK, 32'h0000_0001, rd, err);
    chk_flag(err, 1'b0);
    rd_chk(IDX_IRQ_MASK, 32'h0000_0001);
    $display("test access done");
    // Receiver timeout, its event and the interrupt
    u_hsb_host.xfer(1'b0, IDX_IRQ_STATUS, 32'h0, rd, err);
    pulse_packet();
    repeat (3) @(posedge clock);
    rd_chk(IDX_HEALTH, exp_health(gnss, 6'h0, 1'b0));
    chk_flag(irq, 1'b0);
    repeat (TO_SIM + 5) @(posedge clock);
    rd_chk(IDX_HEALTH, exp_health(gnss, 6'h0, 1'b1));
    chk_flag(irq, 1'b1);
    rd_chk(IDX_IRQ_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk_flag(irq, 1'b0);
    rd_chk(IDX_IRQ_STATUS, 32'h0);
    pulse_packet();
    repeat (3) @(posedge clock);
    rd_chk(IDX_HEALTH, exp_health(gnss, 6'h0, 1'b0));
    $display("test timeout done");
    // Sample, overflow and norm events land in the status word
    @(posedge clock);
    rate_valid <= 1'b1;
    lv <= 6'h30;
    @(posedge clock);
    rate_valid <= 1'b0;
    repeat (4) @(posedge clock);
    rd_chk(IDX_IRQ_STATUS, 32'h0000_000e);
    chk_flag(irq, 1'b0);
    rd_chk(IDX_IRQ_STATUS, 32'h0);
    $display("test events done");
    end_sim();
  end
endmodule
